// >>> design/tai_defines.svh
// Shared constants of the two-axis interpolator: register indices, command
// codes, status/mode/error bit positions and rates. Included by the rate generator and the core.
//
// What this block does
// - Speeds always taken from X; range from X, plus Y's range in vector mode.
// - Interpolation starts on command register write.
// - Interpolation flag high while running, then cleared.
// - Both axis driving flags high while interpolating.
// - Pulse rate capped at 4MPPS.
// - Continuous mode caps rate at 2MPPS.
// - Limit stops interpolation, sets axis error bits.
// - Circle stops on any limit, either direction.
// - Wait for in-position inputs before finishing.
// - Linear finish counts are signed relative coordinates.
// - Long axis even pulses, short by ratio.
// - Endpoints 24-bit signed, most negative refused.
// - Circle center/finish relative, CW or CCW.
// - Finish at origin traces a full circle.
// - Eight octants; X long in 0,3,4,7.
// - Short axis steps regularly, long by error.
// - Circle ends when short coordinate hits finish.
// - Circle stays within one step of ideal.
// - Vector range slows steps that move both axes.
`ifndef TAI_DEFINES_SVH
`define TAI_DEFINES_SVH
// Clock rate 25 MHz and pulse rate ceilings in pulses per second.
`define TAI_CLK_HZ 25'h17d7840
`define TAI_MAX_PPS 24'h3d0900
`define TAI_CONT_PPS 24'h1e8480
// Minimum idle cycles between steps at each ceiling.
`define TAI_GAP_MAX 8'h05
`define TAI_GAP_CONT 8'h0b
// Register word indices; byte address is four times the index.
`define TAI_IDX_CMD 3'h0
`define TAI_IDX_STAT 3'h0
`define TAI_IDX_ERRX 3'h2
`define TAI_IDX_ERRY 3'h3
`define TAI_IDX_MODE 3'h5
`define TAI_IDX_DLO 3'h6
`define TAI_IDX_DHI 3'h7
// Command codes (low byte of command_reg).
`define TAI_CMD_RNG 8'h00
`define TAI_CMD_CMPP 8'h02
`define TAI_CMD_CMPM 8'h03
`define TAI_CMD_ISPD 8'h04
`define TAI_CMD_DSPD 8'h05
`define TAI_CMD_FIN 8'h06
`define TAI_CMD_CTR 8'h08
`define TAI_CMD_LPOS 8'h09
`define TAI_CMD_STOP 8'h27
`define TAI_CMD_LIN 8'h30
`define TAI_CMD_CW 8'h32
`define TAI_CMD_CCW 8'h33
// main_status_reg bits.
`define TAI_ST_XDRV 0
`define TAI_ST_YDRV 1
`define TAI_ST_XERR 4
`define TAI_ST_YERR 5
`define TAI_ST_IDRV 8
// mode_config_reg bits.
`define TAI_MD_CONT 0
`define TAI_MD_XINP 1
`define TAI_MD_YINP 2
`define TAI_MD_XSL 3
`define TAI_MD_YSL 4
`define TAI_MD_VEC 8
// axis_error_reg bits.
`define TAI_ER_SLP 0
`define TAI_ER_SLM 1
`define TAI_ER_HLP 2
`define TAI_ER_HLM 3
// Refused endpoint value.
`define TAI_NEG_MIN 24'h800000
`endif

// >>> design/tai_pkg.sv
// Types of the two-axis interpolator.
// Assumes tai_defines.svh is on the include path.
package tai_pkg;
   typedef enum logic [1:0] {
      TAI_IDLE = 2'b00,
      TAI_LIN = 2'b01,
      TAI_CIRC = 2'b10,
      TAI_INPOS = 2'b11
   } tai_state_t;

   // Pin inputs, index 0 is X, 1 is Y; all active high.
   typedef struct packed {
      logic [1:0] lim_p;
      logic [1:0] lim_m;
      logic [1:0] inp;
   } tai_pins_t;

   typedef struct packed {
      logic [1:0] plus;
      logic [1:0] minus;
   } tai_pulse_t;

   typedef struct packed {
      tai_pins_t s1;
      tai_pins_t s2;
   } tai_sync_t;

   typedef struct packed {
      logic [49:0] acc;
      logic [7:0] gap;
   } tai_rate_t;

   typedef struct packed {
      tai_state_t st;
      logic ack;
      logic [31:0] rdata;
      logic [15:0] mode;
      logic [15:0] dlo;
      logic [15:0] dhi;
      logic [1:0][23:0] rng;
      logic [23:0] isp;
      logic [23:0] dsp;
      logic [1:0][23:0] fin;
      logic [1:0][24:0] ctr;
      logic [1:0][31:0] cmpp;
      logic [1:0][31:0] cmpm;
      logic [1:0][31:0] lpos;
      logic [1:0][24:0] rel;
      logic signed [53:0] r2;
      logic [1:0] err_ax;
      logic [1:0][3:0] erc;
      logic [1:0] pp;
      logic [1:0] pm;
      logic diag;
      logic left;
      logic [2:0] oct0;
      logic ccw;
      logic xlong;
      logic [1:0] sgn;
      logic [23:0] cnt;
      logic [23:0] lng;
      logic [23:0] sht;
      logic [24:0] derr;
   } tai_core_t;
endpackage

// >>> design/tai_sync.sv
// Two-stage synchroniser for the limit and in-position pins.
// Assumes the pins are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module tai_sync (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   // Pins
   input wire tai_pkg::tai_pins_t pin_raw,
   output tai_pkg::tai_pins_t pin_sync
);
   import tai_pkg::*;
   tai_sync_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = pin_raw;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign pin_sync = s_r.s2;
endmodule // tai_sync
`default_nettype wire

// >>> design/tai_rate.sv
// Step rate generator: one tick per step at the X drive speed.
// Assumes speed, ranges and mode come from registers on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "tai_defines.svh"
module tai_rate (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   // Control
   input wire logic run,
   input wire logic [23:0] speed,
   input wire logic [23:0] rng,
   input wire logic [23:0] rng2,
   input wire logic vec_en,
   input wire logic diag,
   input wire logic cont,
   // Step request
   output logic tick
);
   import tai_pkg::*;
   tai_rate_t s_r, s_nxt;
   logic [23:0] cap, spd;
   logic [49:0] inc, thr, sum;

   // Rate = speed * rng / (diag ? rng2 : rng), so a diagonal step in
   // vector mode is stretched by the second range.
   assign cap = cont ? `TAI_CONT_PPS : `TAI_MAX_PPS;
   assign spd = (speed > cap) ? cap : speed;
   assign inc = {26'h0000000, spd} * {26'h0000000, rng};
   assign thr = {25'h0000000, `TAI_CLK_HZ} * {26'h0000000, ((diag && vec_en) ? rng2 : rng)};
   assign sum = s_r.acc + inc;
   assign tick = run && ce && (thr != 50'h0) && (sum >= thr);

   always_comb begin
      s_nxt = s_r;
      s_nxt.acc = !run ? 50'h0 : (tick ? sum - thr : sum);
      s_nxt.gap = tick ? 8'h00 : ((s_r.gap == 8'hff) ? s_r.gap : s_r.gap + 8'h01);
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   a_tick_spacing: assert property (@(posedge mclk) disable iff (!reset_n)
      tick |-> s_r.gap >= `TAI_GAP_MAX) else $error("steps closer than the rate ceiling");
   a_cont_spacing: assert property (@(posedge mclk) disable iff (!reset_n)
      (tick && cont && $stable(cont)) |-> s_r.gap >= `TAI_GAP_CONT) else $error("continuous rate above cap");
endmodule // tai_rate
`default_nettype wire

// >>> design/tai_core.sv
// Two-axis interpolator top: Avalon-MM registers, linear and circular
// interpolation, limit stop and in-position wait.
// Assumes an Avalon-MM master on mclk and asynchronous limit/servo pins.
`timescale 1ns/1ps
`default_nettype none
`include "tai_defines.svh"
module tai_core (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Pins
   input wire tai_pkg::tai_pins_t pins,
   output tai_pkg::tai_pulse_t pulse
);
   import tai_pkg::*;

   // ----------------------------------------
   // Geometry helpers
   // ----------------------------------------
   function automatic logic [2:0] oct_of(input logic signed [25:0] x, input logic signed [25:0] y);
      logic [25:0] ax, ay;
      ax = x[25] ? 26'(-x) : x;
      ay = y[25] ? 26'(-y) : y;
      if (!y[25]) begin
         if (!x[25]) return (ax > ay) ? 3'h0 : 3'h1;
         return (ay >= ax) ? 3'h2 : 3'h3;
      end
      if (x[25]) return (ax > ay) ? 3'h4 : 3'h5;
      return (ay >= ax) ? 3'h6 : 3'h7;
   endfunction

   function automatic logic signed [53:0] rad(input logic signed [25:0] x, input logic signed [25:0] y);
      return 54'(x) * 54'(x) + 54'(y) * 54'(y);
   endfunction

   function automatic logic signed [25:0] ext(input logic [24:0] v);
      return {v[24], v};
   endfunction

   function automatic logic signed [25:0] mv(input logic signed [25:0] v, input logic neg);
      return neg ? v - 26'sh1 : v + 26'sh1;
   endfunction

   function automatic logic xl_of(input logic [2:0] o);
      return (o == 3'h0) || (o == 3'h3) || (o == 3'h4) || (o == 3'h7);
   endfunction

   tai_core_t s_r, s_nxt;
   tai_pins_t ps;
   logic tick, busy, go_wr, go_rd, stop, xl, sneg, lneg, lstep, cend;
   logic [15:0] stat, cmd;
   logic [31:0] data32;
   logic [2:0] idx, oct, ocn, ocf;
   logic [1:0] stepv, negv, slp, slm, hlp, hlm, limp, limm, lim_hit;
   logic signed [25:0] px, py, sx, sy, lx, ly, fx, fy, npx, npy;
   logic signed [53:0] e0, e1;
   logic [24:0] e2;
   logic [23:0] sp;

   tai_sync u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .pin_raw(pins),
      .pin_sync(ps)
   );

   // Drive speed never drops below the initial speed; both are X's.
   assign sp = (s_r.dsp < s_r.isp) ? s_r.isp : s_r.dsp;

   tai_rate u_rate (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .run((s_r.st == TAI_LIN) || (s_r.st == TAI_CIRC)),
      .speed(sp),
      .rng(s_r.rng[0]),
      .rng2(s_r.rng[1]),
      .vec_en(s_r.mode[`TAI_MD_VEC]),
      .diag(s_r.diag),
      .cont(s_r.mode[`TAI_MD_CONT]),
      .tick(tick)
   );

   // ----------------------------------------
   // Bus and status
   // ----------------------------------------
   // One wait cycle per access: read data is registered in the first cycle.
   assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
   assign go_wr = avs_write && s_r.ack;
   assign go_rd = avs_read && !s_r.ack;
   assign idx = avs_address[4:2];
   assign cmd = avs_writedata[15:0];
   assign data32 = {s_r.dhi, s_r.dlo};
   assign busy = s_r.st != TAI_IDLE;
   always_comb begin
      stat = 16'h0000;
      stat[`TAI_ST_IDRV] = busy;
      stat[`TAI_ST_XDRV] = busy;
      stat[`TAI_ST_YDRV] = busy;
      stat[`TAI_ST_XERR] = s_r.err_ax[0];
      stat[`TAI_ST_YERR] = s_r.err_ax[1];
   end

   // ----------------------------------------
   // Limits
   // ----------------------------------------
   generate
      for (genvar a = 0; a < 2; a++) begin : g_lim
         assign slp[a] = s_r.mode[`TAI_MD_XSL + a] && ($signed(s_r.lpos[a]) > $signed(s_r.cmpp[a]));
         assign slm[a] = s_r.mode[`TAI_MD_XSL + a] && ($signed(s_r.lpos[a]) < $signed(s_r.cmpm[a]));
         assign hlp[a] = ps.lim_p[a];
         assign hlm[a] = ps.lim_m[a];
         assign limp[a] = slp[a] || hlp[a];
         assign limm[a] = slm[a] || hlm[a];
         // Linear checks only the moving direction; the circle checks both.
         assign lim_hit[a] = (s_r.st == TAI_CIRC) ? (limp[a] || limm[a])
            : ((s_r.fin[a] != 24'h0) && (s_r.sgn[a] ? limm[a] : limp[a]));
      end
   endgenerate
   assign stop = ((s_r.st == TAI_LIN) || (s_r.st == TAI_CIRC)) && (lim_hit != 2'b00);

   // ----------------------------------------
   // Circle step decision
   // ----------------------------------------
   assign px = ext(s_r.rel[0]) - ext(s_r.ctr[0]);
   assign py = ext(s_r.rel[1]) - ext(s_r.ctr[1]);
   assign oct = oct_of(px, py);
   assign xl = xl_of(oct);
   assign sneg = xl ? (s_r.ccw ? px[25] : (px > 26'sh0)) : (s_r.ccw ? (py > 26'sh0) : py[25]);
   // The long axis follows the tangent, which can carry it away from the centre.
   assign lneg = xl ? (s_r.ccw ? (py > 26'sh0) : py[25]) : (s_r.ccw ? px[25] : (px > 26'sh0));
   assign sx = xl ? px : mv(px, sneg);
   assign sy = xl ? mv(py, sneg) : py;
   assign lx = xl ? mv(sx, lneg) : sx;
   assign ly = xl ? sy : mv(sy, lneg);
   assign e0 = rad(sx, sy) - s_r.r2;
   assign e1 = rad(lx, ly) - s_r.r2;
   // Take the long step only when it lands nearer the true radius.
   assign lstep = ((e1 < 0) ? -e1 : e1) < ((e0 < 0) ? -e0 : e0);
   assign fx = {s_r.fin[0][23], s_r.fin[0][23], s_r.fin[0]} - ext(s_r.ctr[0]);
   assign fy = {s_r.fin[1][23], s_r.fin[1][23], s_r.fin[1]} - ext(s_r.ctr[1]);
   assign ocf = oct_of(fx, fy);
   assign npx = xl ? lx : sx;
   assign npy = xl ? sy : ly;
   assign ocn = oct_of(npx, npy);
   // A zero finish point needs the path to have left its first octant.
   assign cend = (ocn == ocf) && (s_r.left || (s_r.fin != '0) || (ocn != s_r.oct0))
      && (xl_of(ocf) ? (npy + ext(s_r.ctr[1]) == {s_r.fin[1][23], s_r.fin[1][23], s_r.fin[1]})
                     : (npx + ext(s_r.ctr[0]) == {s_r.fin[0][23], s_r.fin[0][23], s_r.fin[0]}));

   // ----------------------------------------
   // Linear step decision
   // ----------------------------------------
   assign e2 = s_r.derr + {1'b0, s_r.sht};
   always_comb begin
      stepv = 2'b00;
      negv = 2'b00;
      if (s_r.st == TAI_CIRC) begin
         stepv = xl ? {1'b1, lstep} : {lstep, 1'b1};
         negv = xl ? {sneg, lneg} : {lneg, sneg};
      end else begin
         // Long axis steps every tick, short when twice the error reaches it.
         stepv[s_r.xlong ? 0 : 1] = 1'b1;
         // The error term goes negative after a short step, so compare signed.
         stepv[s_r.xlong ? 1 : 0] = $signed({e2, 1'b0}) >= $signed({2'b00, s_r.lng});
         negv = s_r.sgn;
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = (avs_read || avs_write) && !s_r.ack;
      s_nxt.pp = 2'b00;
      s_nxt.pm = 2'b00;
      if (go_rd) begin
         if (idx == `TAI_IDX_STAT) begin
            s_nxt.rdata = {16'h0000, stat};
         end else if (idx == `TAI_IDX_ERRX) begin
            s_nxt.rdata = {28'h0000000, s_r.erc[0]};
         end else if (idx == `TAI_IDX_ERRY) begin
            s_nxt.rdata = {28'h0000000, s_r.erc[1]};
         end else if (idx == `TAI_IDX_MODE) begin
            s_nxt.rdata = {16'h0000, s_r.mode};
         end else if (idx == `TAI_IDX_DLO) begin
            s_nxt.rdata = {16'h0000, s_r.dlo};
         end else if (idx == `TAI_IDX_DHI) begin
            s_nxt.rdata = {16'h0000, s_r.dhi};
         end else begin
            s_nxt.rdata = 32'h00000000;
         end
      end
      case (s_r.st)
         TAI_LIN, TAI_CIRC: begin
            if (stop) begin
               s_nxt.st = TAI_IDLE;
               for (int a = 0; a < 2; a++) begin
                  if (lim_hit[a]) begin
                     s_nxt.err_ax[a] = 1'b1;
                     s_nxt.erc[a] = {hlm[a], hlp[a], slm[a], slp[a]};
                  end
               end
            end else if ((s_r.st == TAI_LIN) && (s_r.cnt == 24'h0)) begin
               s_nxt.st = TAI_INPOS;
            end else if (tick) begin
               s_nxt.diag = &stepv;
               for (int a = 0; a < 2; a++) begin
                  if (stepv[a]) begin
                     s_nxt.pp[a] = !negv[a];
                     s_nxt.pm[a] = negv[a];
                     s_nxt.rel[a] = negv[a] ? s_r.rel[a] - 25'h1 : s_r.rel[a] + 25'h1;
                     s_nxt.lpos[a] = negv[a] ? s_r.lpos[a] - 32'h1 : s_r.lpos[a] + 32'h1;
                  end
               end
               if (s_r.st == TAI_LIN) begin
                  s_nxt.cnt = s_r.cnt - 24'h1;
                  s_nxt.derr = stepv[s_r.xlong ? 1 : 0] ? e2 - {1'b0, s_r.lng} : e2;
               end else begin
                  if (ocn != s_r.oct0) s_nxt.left = 1'b1;
                  if (cend) s_nxt.st = TAI_INPOS;
               end
            end
         end
         TAI_INPOS: begin
            // Pulses are done; hold the flags until enabled servos settle.
            if ((!s_r.mode[`TAI_MD_XINP] || ps.inp[0]) && (!s_r.mode[`TAI_MD_YINP] || ps.inp[1])) begin
               s_nxt.st = TAI_IDLE;
            end
         end
         default: begin
         end
      endcase
      if (go_wr) begin
         if (idx == `TAI_IDX_CMD) begin
            if (cmd[7:0] == `TAI_CMD_STOP) begin
               s_nxt.st = TAI_IDLE;
            end else if (!busy && (cmd[15:8] == 8'h00) && (cmd[7:0] == `TAI_CMD_LIN)) begin
               s_nxt.st = TAI_LIN;
               s_nxt.rel = '0;
               s_nxt.err_ax = 2'b00;
               s_nxt.erc = '0;
               s_nxt.sgn = {s_r.fin[1][23], s_r.fin[0][23]};
               s_nxt.xlong = (s_r.fin[0][23] ? 24'(-s_r.fin[0]) : s_r.fin[0])
                  >= (s_r.fin[1][23] ? 24'(-s_r.fin[1]) : s_r.fin[1]);
               s_nxt.lng = s_nxt.xlong ? (s_r.fin[0][23] ? 24'(-s_r.fin[0]) : s_r.fin[0])
                  : (s_r.fin[1][23] ? 24'(-s_r.fin[1]) : s_r.fin[1]);
               s_nxt.sht = s_nxt.xlong ? (s_r.fin[1][23] ? 24'(-s_r.fin[1]) : s_r.fin[1])
                  : (s_r.fin[0][23] ? 24'(-s_r.fin[0]) : s_r.fin[0]);
               s_nxt.cnt = s_nxt.lng;
               s_nxt.derr = 25'h0;
               s_nxt.diag = 1'b0;
            end else if (!busy && (cmd[15:8] == 8'h00)
                         && ((cmd[7:0] == `TAI_CMD_CW) || (cmd[7:0] == `TAI_CMD_CCW))) begin
               s_nxt.st = TAI_CIRC;
               s_nxt.ccw = cmd[7:0] == `TAI_CMD_CCW;
               s_nxt.rel = '0;
               s_nxt.err_ax = 2'b00;
               s_nxt.erc = '0;
               s_nxt.r2 = rad(-ext(s_r.ctr[0]), -ext(s_r.ctr[1]));
               s_nxt.oct0 = oct_of(-ext(s_r.ctr[0]), -ext(s_r.ctr[1]));
               s_nxt.left = 1'b0;
               s_nxt.diag = 1'b0;
            end else begin
               for (int a = 0; a < 2; a++) begin
                  if (cmd[8 + a]) begin
                     if (cmd[7:0] == `TAI_CMD_RNG) s_nxt.rng[a] = data32[23:0];
                     if (cmd[7:0] == `TAI_CMD_CMPP) s_nxt.cmpp[a] = data32;
                     if (cmd[7:0] == `TAI_CMD_CMPM) s_nxt.cmpm[a] = data32;
                     if (cmd[7:0] == `TAI_CMD_LPOS) s_nxt.lpos[a] = data32;
                     if (cmd[7:0] == `TAI_CMD_CTR) s_nxt.ctr[a] = data32[24:0];
                     if ((cmd[7:0] == `TAI_CMD_FIN) && (data32[23:0] != `TAI_NEG_MIN)) begin
                        s_nxt.fin[a] = data32[23:0];
                     end
                     // Speeds are kept for X only; Y's never steer the engine.
                     if ((a == 0) && (cmd[7:0] == `TAI_CMD_ISPD)) s_nxt.isp = data32[23:0];
                     if ((a == 0) && (cmd[7:0] == `TAI_CMD_DSPD)) s_nxt.dsp = data32[23:0];
                  end
               end
            end
         end else if (idx == `TAI_IDX_MODE) begin
            s_nxt.mode = avs_writedata[15:0];
         end else if (idx == `TAI_IDX_DLO) begin
            s_nxt.dlo = avs_writedata[15:0];
         end else if (idx == `TAI_IDX_DHI) begin
            s_nxt.dhi = avs_writedata[15:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign avs_readdata = s_r.rdata;
   assign pulse.plus = s_r.pp;
   assign pulse.minus = s_r.pm;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_start_flags: assert property (@(posedge mclk) disable iff (!reset_n)
      (ce && go_wr && !busy && (idx == `TAI_IDX_CMD) && (cmd == {8'h00, `TAI_CMD_LIN})) |=> stat[`TAI_ST_IDRV])
      else $error("linear command did not raise the driving flag");
   a_idle_flag: assert property (@(posedge mclk) disable iff (!reset_n)
      (s_r.st == TAI_IDLE) |-> !stat[`TAI_ST_IDRV]) else $error("driving flag set while idle");
   a_axis_flags: assert property (@(posedge mclk) disable iff (!reset_n)
      stat[`TAI_ST_IDRV] |-> (stat[`TAI_ST_XDRV] && stat[`TAI_ST_YDRV])) else $error("axis flags low while interpolating");
   a_limit_stop: assert property (@(posedge mclk) disable iff (!reset_n)
      (ce && stop && lim_hit[0] && !go_wr) |=> (s_r.st == TAI_IDLE) && stat[`TAI_ST_XERR])
      else $error("X limit did not stop with error");
   a_circ_any_limit: assert property (@(posedge mclk) disable iff (!reset_n)
      (ce && (s_r.st == TAI_CIRC) && (hlm[1] || hlp[1]) && !go_wr) |=> !busy)
      else $error("circle kept running on a Y limit");
   a_inpos_hold: assert property (@(posedge mclk) disable iff (!reset_n)
      ((s_r.st == TAI_INPOS) && s_r.mode[`TAI_MD_XINP] && !ps.inp[0]) |-> stat[`TAI_ST_IDRV])
      else $error("finished before X in-position");
   a_pos_follow: assert property (@(posedge mclk) disable iff (!reset_n)
      (s_r.pp[0] && $past(ce)) |-> (s_r.lpos[0] == $past(s_r.lpos[0]) + 32'h1))
      else $error("X logical position not counted up");
   a_lin_error: assert property (@(posedge mclk) disable iff (!reset_n)
      (s_r.st == TAI_LIN) |-> (s_r.lng == 24'h0)
         || (($signed(s_r.derr) < $signed({1'b0, s_r.lng})) && ($signed(s_r.derr) >= -$signed({1'b0, s_r.lng}))))
      else $error("linear error term out of range");
   a_circ_short: assert property (@(posedge mclk) disable iff (!reset_n)
      (ce && tick && (s_r.st == TAI_CIRC) && !stop && !go_wr) |=> ((s_r.pp | s_r.pm) != 2'b00))
      else $error("circle tick without a pulse");
   a_no_neg_min: assert property (@(posedge mclk) disable iff (!reset_n)
      (s_r.fin[0] != `TAI_NEG_MIN) && (s_r.fin[1] != `TAI_NEG_MIN)) else $error("most negative endpoint stored");
endmodule // tai_core
`default_nettype wire

// >>> tb/tai_drive_model.sv
// Motor driver and servo model: counts pulses, reports in-position and limits.
// Assumes one-cycle pulses from the interpolator on mclk.
`timescale 1ns/1ps
`default_nettype none
module tai_drive_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Drive side
   input wire tai_pkg::tai_pulse_t pulse,
   input wire logic [1:0] lim_p,
   input wire logic hold,
   output var tai_pkg::tai_pins_t pins,
   output var int xpos,
   output var int ypos
);
   import tai_pkg::*;
   logic [3:0] settle_r;
   // The servo is not settled for a while after each pulse, so in-position lags.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         settle_r <= 4'h0;
         xpos <= 0;
         ypos <= 0;
      end else begin
         xpos <= xpos + pulse.plus[0] - pulse.minus[0];
         ypos <= ypos + pulse.plus[1] - pulse.minus[1];
         settle_r <= (|pulse) ? 4'h8 : settle_r - (settle_r != 4'h0);
      end
   end
   assign pins.inp = {2{settle_r == 4'h0 && !hold}};
   assign pins.lim_p = lim_p;
   assign pins.lim_m = 2'b00;
endmodule // tai_drive_model
`default_nettype wire

// >>> tb/testbench.sv
// Testbench: runs moves through the Avalon-MM registers and checks the results.
// Assumes the design sources and the drive model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tai_pkg::*;
   logic mclk = 0, reset_n = 0, avs_read = 0, avs_write = 0, hold = 0, ce = 1, avs_waitrequest;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [1:0] lim_p = 2'b00;
   tai_pins_t pins;
   tai_pulse_t pulse;
   int xpos, ypos, x0, y0, i, errors = 0, n_compared = 0;
   always #20 mclk = ~mclk;
   tai_core dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins), .pulse(pulse));
   tai_drive_model drv (.mclk(mclk), .reset_n(reset_n), .pulse(pulse), .lim_p(lim_p),
      .hold(hold), .pins(pins), .xpos(xpos), .ypos(ypos));
   task automatic final_report;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 50) begin
         errors++;
         final_report;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask
   // Parameter word pair, then the command that files it.
   task automatic par(input logic [15:0] cmd, input logic [31:0] v);
      av(1'b1, 5'h18, {16'h0, v[15:0]});
      av(1'b1, 5'h1c, {16'h0, v[31:16]});
      av(1'b1, 5'h00, {16'h0, cmd});
   endtask
   task automatic go(input logic [15:0] cmd);
      x0 = xpos;
      y0 = ypos;
      av(1'b1, 5'h00, {16'h0, cmd});
      av(1'b0, 5'h00, 32'h0);
      check(q, 32'h103);
   endtask
   task automatic wait_idle;
      for (i = 0; i < 3000; i++) begin
         av(1'b0, 5'h00, 32'h0);
         if (q[8] === 1'b0) break;
      end
      if (i == 3000) begin
         errors++;
         final_report;
      end
   endtask
   task automatic wait_pos(input int tx, input int ty);
      for (i = 0; i < 20000 && !(xpos - x0 == tx && ypos - y0 == ty); i++) @(posedge mclk);
      if (i == 20000) begin
         errors++;
         final_report;
      end
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      av(1'b0, 5'h00, 32'h0);
      check(q, 32'h0);
      av(1'b0, 5'h04, 32'h0);
      check(q, 32'h0);
      av(1'b1, 5'h14, 32'h0);
      par(16'h0100, 32'h1);
      par(16'h0105, 32'hffff);
      par(16'h0106, 32'h5);
      par(16'h0106, 32'h800000);
      par(16'h0206, 32'h1);
      go(16'h0030);
      wait_idle;
      check(xpos - x0, 32'h5);
      check(ypos - y0, 32'h1);
      par(16'h0106, 32'h64);
      par(16'h0206, 32'h0);
      go(16'h0030);
      wait_pos(2, 0);
      lim_p <= 2'b01;
      wait_idle;
      check(q, 32'h010);
      av(1'b0, 5'h08, 32'h0);
      check(q, 32'h4);
      lim_p <= 2'b00;
      av(1'b1, 5'h14, 32'h6);
      hold <= 1'b1;
      par(16'h0106, 32'h2);
      par(16'h0206, 32'hfffffe);
      go(16'h0030);
      wait_pos(2, -2);
      repeat (40) @(posedge mclk);
      ce <= 1'b0;
      hold <= 1'b0;
      repeat (40) @(posedge mclk);
      hold <= 1'b1;
      ce <= 1'b1;
      av(1'b0, 5'h00, 32'h0);
      check(q, 32'h103);
      hold <= 1'b0;
      wait_idle;
      check(q, 32'h0);
      par(16'h0108, 32'h1fffffd);
      par(16'h0208, 32'h0);
      par(16'h0106, 32'h0);
      par(16'h0206, 32'h0);
      go(16'h0032);
      wait_idle;
      check(xpos - x0, 32'h0);
      check(ypos - y0, 32'h0);
      go(16'h0032);
      wait_pos(0, -1);
      lim_p <= 2'b10;
      wait_idle;
      check(q, 32'h020);
      av(1'b0, 5'h0c, 32'h0);
      check(q, 32'h4);
      final_report;
   end
endmodule // testbench
`default_nettype wire
